// >>> src/pcg_peripheral_clock_gating.sv
// top: peripheral disable registers, register port and clock gate outputs
`timescale 1ns/1ps
// Overview of operation
// - A set disable bit stops every clock to its peripheral.
// - While a peripheral is off, its own register writes are blocked and reads are undefined.
// - A peripheral runs only if its bit is clear and it is present in the variant.
// - Both disable registers reset to all zeros so every present peripheral starts on.
// - Setting a disable bit turns the peripheral off one cycle later.
// - Clearing a disable bit turns the peripheral back on one cycle later.
// - The converter interface bit stays read/write even when that block is absent.
// - Group two holds captures eight..one in bits 15..8 and compares eight..one in 7..0.
module pcg_peripheral_clock_gating
  import pcg_pkg::*;
(
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  // register port
  input  wire logic [PCG_ADDR_W-1:0]     reg_addr,
  input  wire logic [PCG_DATA_W-1:0]     reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [PCG_DATA_W-1:0]     reg_rdata,
  // variant presence, one bit per peripheral in register bit order
  input  wire logic [PCG_NUM_PERIPH-1:0] periph_present,
  // per peripheral clock enable and register access enable
  output logic      [PCG_NUM_PERIPH-1:0] periph_clk_en,
  output logic      [PCG_NUM_PERIPH-1:0] periph_reg_en
);
  logic [PCG_DATA_W-1:0] group_one;
  logic [PCG_DATA_W-1:0] group_two;
  logic [PCG_DATA_W-1:0] next_group_one;
  logic [PCG_DATA_W-1:0] next_group_two;
  logic [PCG_DATA_W-1:0] rdata_q;
  logic [PCG_DATA_W-1:0] next_rdata_q;
  logic [PCG_NUM_PERIPH-1:0] run_vec;
  logic [1:0]                addr_hit;

  pcg_gate_if gate_bus ();

  // address decode shared by write and read paths
  function automatic logic [1:0] pcg_decode(input logic [PCG_ADDR_W-1:0] a);
    pcg_decode = {a == PCG_GROUP_TWO_OFS, a == PCG_GROUP_ONE_OFS};
  endfunction : pcg_decode

  // one decode feeds both paths; a call result cannot be bit-selected directly
  assign addr_hit = pcg_decode(reg_addr);

  // register writes; unused bits are masked so they stay zero
  always_comb begin
    next_group_one = group_one;
    next_group_two = group_two;
    if (reg_write && addr_hit[0]) begin
      next_group_one = reg_wdata & PCG_GROUP_ONE_MASK;
    end
    if (reg_write && addr_hit[1]) begin
      next_group_two = reg_wdata & PCG_GROUP_TWO_MASK;
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    next_rdata_q = '0;
    if (reg_read && addr_hit[0]) begin
      next_rdata_q = group_one;
    end else if (reg_read && addr_hit[1]) begin
      next_rdata_q = group_two;
    end
  end

  // state registers; synchronous reset clears both groups and the read data
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      group_one <= PCG_GROUP_ONE_RST;
      group_two <= PCG_GROUP_TWO_RST;
      rdata_q   <= '0;
    end else begin
      group_one <= next_group_one;
      group_two <= next_group_two;
      rdata_q   <= next_rdata_q;
    end
  end

  // index 0..15 is group one bit for bit and 16..31 group two, so presence uses the
  // same order; the unused bits 10 and 9 stay zero and leave their slots running
  // whenever the variant reports something present there
  // register bits map straight to peripheral index: group two above group one
  assign gate_bus.off_req = {group_two, group_one};

  pcg_gate_stage u_gate (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .gate           (gate_bus),
    .periph_present (periph_present),
    .periph_run     (run_vec)
  );

  // the same enable stops the clock and freezes the peripheral's registers
  assign periph_clk_en = run_vec;
  assign periph_reg_en = run_vec;
  assign reg_rdata     = rdata_q;

  // assertions
  chk_off_stops_clk: assert property (@(posedge sys_clk) disable iff (!reset_n)
    gate_bus.off_req[0] |=> !periph_clk_en[0])
    else $error("clock not stopped for disabled peripheral");
  chk_reg_en_tracks: assert property (@(posedge sys_clk) disable iff (!reset_n)
    periph_reg_en == periph_clk_en)
    else $error("register enable differs from clock enable");
  chk_absent_never_runs: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !$past(periph_present[8]) |-> !periph_clk_en[8])
    else $error("absent peripheral running");
  chk_reset_clears: assert property (@(posedge sys_clk)
    !reset_n |=> (group_one == 16'h0000 && group_two == 16'h0000))
    else $error("disable registers not cleared by reset");
  chk_set_latency: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_TWO_OFS && reg_wdata[3]) ##1 1
      |=> !periph_clk_en[19])
    else $error("disable not effective one cycle after setting");
  chk_clear_latency: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_TWO_OFS && !reg_wdata[3]) ##1 periph_present[19]
      |=> periph_clk_en[19])
    else $error("enable not restored one cycle after clearing");
  chk_conv_iface_rw: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_ONE_OFS) ##1 (reg_read && reg_addr == PCG_GROUP_ONE_OFS
      && !reg_write) |=> reg_rdata[8] == $past(reg_wdata[8], 2))
    else $error("converter interface bit not read back");
  chk_unused_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    group_one[10:9] == 2'b00)
    else $error("unused bits of group one not zero");
  chk_group_two_rw: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_TWO_OFS) |=> group_two == $past(reg_wdata))
    else $error("group two write lost");
  chk_timer_field: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_ONE_OFS) |=> group_one[15:11] == $past(reg_wdata[15:11]))
    else $error("timer bits of group one not stored");

  // named fields: a write that sets a field stops that peripheral two edges later
  chk_analog_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_ONE_OFS && reg_wdata[PCG_ANALOG_CONVERTER_BIT]) ##1 1
      |=> !periph_clk_en[PCG_ANALOG_CONVERTER_BIT])
    else $error("analog converter bit does not stop its peripheral");
  chk_can1_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_ONE_OFS && reg_wdata[PCG_CAN1_BIT]) ##1 1
      |=> !periph_clk_en[PCG_CAN1_BIT])
    else $error("can1 bit does not stop its peripheral");
  chk_can2_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_ONE_OFS && reg_wdata[PCG_CAN2_BIT]) ##1 1
      |=> !periph_clk_en[PCG_CAN2_BIT])
    else $error("can2 bit does not stop its peripheral");
  chk_serial1_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_ONE_OFS && reg_wdata[PCG_SERIAL_PERIPH1_BIT]) ##1 1
      |=> !periph_clk_en[PCG_SERIAL_PERIPH1_BIT])
    else $error("serial port one bit does not stop its peripheral");
  chk_serial2_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_ONE_OFS && reg_wdata[PCG_SERIAL_PERIPH2_BIT]) ##1 1
      |=> !periph_clk_en[PCG_SERIAL_PERIPH2_BIT])
    else $error("serial port two bit does not stop its peripheral");
  chk_uart1_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_ONE_OFS && reg_wdata[PCG_UART1_BIT]) ##1 1
      |=> !periph_clk_en[PCG_UART1_BIT])
    else $error("uart1 bit does not stop its peripheral");
  chk_uart2_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_ONE_OFS && reg_wdata[PCG_UART2_BIT]) ##1 1
      |=> !periph_clk_en[PCG_UART2_BIT])
    else $error("uart2 bit does not stop its peripheral");
  chk_two_wire_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_ONE_OFS && reg_wdata[PCG_TWO_WIRE_PORT_BIT]) ##1 1
      |=> !periph_clk_en[PCG_TWO_WIRE_PORT_BIT])
    else $error("two wire port bit does not stop its peripheral");
  chk_conv_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_ONE_OFS && reg_wdata[PCG_CONVERTER_IFACE_BIT]) ##1 1
      |=> !periph_clk_en[PCG_CONVERTER_IFACE_BIT])
    else $error("converter interface bit does not stop its peripheral");
  chk_timer1_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_ONE_OFS && reg_wdata[PCG_TIMER1_BIT]) ##1 1
      |=> !periph_clk_en[PCG_TIMER1_BIT])
    else $error("timer1 bit does not stop its peripheral");
  chk_capture1_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_TWO_OFS && reg_wdata[PCG_CAPTURE1_BIT]) ##1 1
      |=> !periph_clk_en[PCG_DATA_W + PCG_CAPTURE1_BIT])
    else $error("capture1 bit does not stop its peripheral");
  chk_compare1_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_write && reg_addr == PCG_GROUP_TWO_OFS && reg_wdata[PCG_COMPARE1_BIT]) ##1 1
      |=> !periph_clk_en[PCG_DATA_W + PCG_COMPARE1_BIT])
    else $error("compare1 bit does not stop its peripheral");

  // read-back stands in the cycle after the strobe
  chk_read_one: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_read && reg_addr == PCG_GROUP_ONE_OFS) |=> reg_rdata == $past(group_one))
    else $error("group one read returns wrong value");
  chk_read_two: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_read && reg_addr == PCG_GROUP_TWO_OFS) |=> reg_rdata == $past(group_two))
    else $error("group two read returns wrong value");
  chk_read_unused: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_read && reg_addr == PCG_GROUP_ONE_OFS) |=> reg_rdata[10:9] == 2'b00)
    else $error("unused bits of group one read as nonzero");

  // leaving reset every present peripheral comes up running
  chk_reset_enables: assert property (@(posedge sys_clk)
    !reset_n ##1 reset_n |=> periph_clk_en == $past(periph_present))
    else $error("present peripherals not enabled after reset");
  chk_reg_en_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    gate_bus.off_req[PCG_DATA_W] |=> !periph_reg_en[PCG_DATA_W])
    else $error("register access left open for disabled peripheral");

  // every enable is last cycle's presence and disable request, index by index
  for (genvar gp = 0; gp < PCG_NUM_PERIPH; gp++) begin : g_chk_gate
    chk_gate_follows: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $past(reset_n) |-> periph_clk_en[gp] ==
        ($past(periph_present[gp]) & ~$past(gate_bus.off_req[gp])))
      else $error("enable differs from last presence and disable bit");
  end : g_chk_gate

  // scenarios worth seeing in a run
  cov_disable_one: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(periph_clk_en[0]));
  cov_enable_again: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(periph_clk_en[0]));
  cov_read_two: cover property (@(posedge sys_clk) disable iff (!reset_n)
    reg_read && reg_addr == PCG_GROUP_TWO_OFS);
  cov_write_then_read: cover property (@(posedge sys_clk) disable iff (!reset_n)
    reg_write ##1 reg_read);
  cov_absent_idle: cover property (@(posedge sys_clk) disable iff (!reset_n)
    !periph_present[PCG_CONVERTER_IFACE_BIT] && !periph_clk_en[PCG_CONVERTER_IFACE_BIT]);
endmodule : pcg_peripheral_clock_gating

// >>> common/pcg_pkg.sv
// package: register map, field layout and timing for the peripheral clock gating block
package pcg_pkg;
  localparam int          PCG_ADDR_W        = 16;
  localparam int          PCG_DATA_W        = 16;
  localparam int          PCG_NUM_PERIPH    = 32;
  localparam logic [15:0] PCG_GROUP_ONE_OFS = 16'h0770;
  localparam logic [15:0] PCG_GROUP_TWO_OFS = 16'h0772;
  localparam logic [15:0] PCG_GROUP_ONE_RST = 16'h0000;
  localparam logic [15:0] PCG_GROUP_TWO_RST = 16'h0000;
  // implemented bits of group one; bits 10 and 9 are unused
  localparam logic [15:0] PCG_GROUP_ONE_MASK = 16'hf9ff;
  localparam logic [15:0] PCG_GROUP_TWO_MASK = 16'hffff;
  // group one field positions
  localparam int PCG_ANALOG_CONVERTER_BIT  = 0;
  localparam int PCG_CAN1_BIT              = 1;
  localparam int PCG_CAN2_BIT              = 2;
  localparam int PCG_SERIAL_PERIPH1_BIT    = 3;
  localparam int PCG_SERIAL_PERIPH2_BIT    = 4;
  localparam int PCG_UART1_BIT             = 5;
  localparam int PCG_UART2_BIT             = 6;
  localparam int PCG_TWO_WIRE_PORT_BIT     = 7;
  localparam int PCG_CONVERTER_IFACE_BIT   = 8;
  localparam int PCG_TIMER1_BIT            = 11;
  // group two field positions
  localparam int PCG_COMPARE1_BIT          = 0;
  localparam int PCG_CAPTURE1_BIT          = 8;
  // latency from register change to gate change, in instruction cycles
  localparam int PCG_LATENCY_CYCLES        = 1;
endpackage : pcg_pkg

// >>> common/pcg_gate_if.sv
// interface: disable vector passed from the register file to the gating stage
`timescale 1ns/1ps
interface pcg_gate_if;
  import pcg_pkg::*;
  logic [PCG_NUM_PERIPH-1:0] off_req;
  modport src (output off_req);
  modport dst (input  off_req);
endinterface : pcg_gate_if

// >>> src/pcg_gate_stage.sv
// gating stage: one-cycle delayed enable per peripheral, masked by presence
`timescale 1ns/1ps
module pcg_gate_stage
  import pcg_pkg::*;
(
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  // disable request from the register file
  pcg_gate_if.dst                        gate,
  // variant presence
  input  wire logic [PCG_NUM_PERIPH-1:0] periph_present,
  // gated enables
  output logic      [PCG_NUM_PERIPH-1:0] periph_run
);
  logic [PCG_NUM_PERIPH-1:0] run_q;
  logic [PCG_NUM_PERIPH-1:0] next_run_q;

  // each peripheral runs only when present and not turned off
  genvar gi;
  for (gi = 0; gi < PCG_NUM_PERIPH; gi++) begin : g_run
    always_comb begin
      next_run_q[gi] = periph_present[gi] & ~gate.off_req[gi];
    end
  end

  // register stage gives the one-cycle latency on set and clear alike
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      run_q <= '0;
    end else begin
      run_q <= next_run_q;
    end
  end

  assign periph_run = run_q;
endmodule : pcg_gate_stage

// >>> verification/tb_top.sv
// testbench: register port and gate enable checks for peripheral clock gating
`timescale 1ns/1ps
module tb_top;
  import pcg_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        rd_q = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] g1 = 16'h0000;
  logic [15:0] g2 = 16'h0000;
  logic [15:0] reg_rdata;
  logic [31:0] periph_present = 32'hffffffff;
  logic [31:0] periph_clk_en;
  logic [31:0] periph_reg_en;
  logic [31:0] lfsr = 32'hcac0;
  logic [15:0] exp_q[$];
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #2 sys_clk = ~sys_clk;
  pcg_peripheral_clock_gating dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .periph_present(periph_present), .periph_clk_en(periph_clk_en),
    .periph_reg_en(periph_reg_en));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  // random source for data and presence
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // read: expected value noted in the queue, the monitor compares it one cycle later
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
  endtask : rd
  // write, then check enables hold one edge and follow on the next
  task automatic wr_chk(input logic [15:0] a, input logic [15:0] d, input logic [31:0] pres);
    logic [31:0] old_off;
    old_off = {g2, g1};
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    periph_present <= pres;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    if (a == PCG_GROUP_ONE_OFS) g1 = d & 16'hf9ff;
    else if (a == PCG_GROUP_TWO_OFS) g2 = d;
    @(negedge sys_clk);
    check("clk_en_hold", periph_clk_en, pres & ~old_off);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check("clk_en", periph_clk_en, pres & ~{g2, g1});
    check("reg_en", periph_reg_en, pres & ~{g2, g1});
  endtask : wr_chk
  // write group one and read it back in the very next cycle, no gap
  task automatic wr_rd(input logic [15:0] d);
    exp_q.push_back(d & 16'hf9ff);
    @(posedge sys_clk);
    reg_addr <= PCG_GROUP_ONE_OFS;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    g1 = d & 16'hf9ff;
  endtask : wr_rd
  // monitor: read data stand only in the cycle after the strobe
  always @(posedge sys_clk) rd_q <= reg_read;
  always @(negedge sys_clk) begin
    if (rd_q) check("rdata", {16'h0000, reg_rdata}, {16'h0000, exp_q.pop_front()});
  end
  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    logic [15:0] a;
    logic [15:0] d;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(PCG_GROUP_ONE_OFS, 16'h0000);
    rd(PCG_GROUP_TWO_OFS, 16'h0000);
    @(negedge sys_clk);
    check("clk_en_rst", periph_clk_en, 32'hffffffff);
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      a = (i % 3 == 0) ? PCG_GROUP_ONE_OFS : (i % 3 == 1) ? PCG_GROUP_TWO_OFS : 16'h0774;
      d = (i < 3) ? 16'hffff : (i < 6) ? 16'h0000 : lfsr[15:0];
      wr_chk(a, d, (i < 6) ? 32'hffffffff : {lfsr[15:0], lfsr[31:16]});
      rd(PCG_GROUP_ONE_OFS, g1);
      rd(PCG_GROUP_TWO_OFS, g2);
      rd(16'h0774, 16'h0000);
      wr_rd(lfsr[31:16]);
    end
    // second reset in mid-run, with dirty registers and random presence
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    g1 = 16'h0000;
    g2 = 16'h0000;
    rd(PCG_GROUP_ONE_OFS, 16'h0000);
    rd(PCG_GROUP_TWO_OFS, 16'h0000);
    @(negedge sys_clk);
    check("clk_en_rerst", periph_clk_en, periph_present);
    repeat (2) @(posedge sys_clk);
    conclude();
  end
endmodule : tb_top
